/* rtl/ari_arith_unit.sv */
`timescale 1ns/10ps
// Functional notes
// - four operations: sum, difference a minus b, product, quotient a over b.
// - operation select resets to addition unless another mode is configured.
// - operands are signed two's complement over the full 32-bit range.
// - result is a signed 32-bit integer, no fraction.
// - out-of-range result sets overflow and keeps the previous valid result.
// - result reads zero after reset until a valid operation completes.
// - quotient truncates toward zero with correct sign.
// - divide by zero sets overflow and holds the last valid result.
// - largest positive plus one is overflow, result held.
// - most negative minus a positive value is overflow, result held.
// - product beyond signed 32-bit range is overflow even if unsigned fits.
// - evaluation time is 32, 33, 38, 41 us by operation.
// - runs continuously, no enable or start; mode load is the only control.
// - zero flag is set whenever a completed evaluation leaves the result output at zero.
`include "ari_cfg.svh"

module ari_arith_unit
#(
  parameter ari_pkg::ari_mode_t INIT_MODE = ari_pkg::ARI_OP_SUM,
  parameter int                 CNT_W     = 9
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 cfg_mode_load,
  input  wire ari_pkg::ari_mode_t   cfg_mode,
  input  wire ari_pkg::ari_operands_t operands,
  output logic signed [31:0]        result_out,
  output ari_pkg::ari_flags_t       flags,
  output logic                      eval_done
);
  import ari_pkg::*;

  // =========================================================================
  // parameter checks
  // =========================================================================
  localparam int LAT_SUM      = `ARI_CYC(`ARI_T_SUM_US);
  localparam int LAT_DIFF     = `ARI_CYC(`ARI_T_DIFF_US);
  localparam int LAT_PRODUCT  = `ARI_CYC(`ARI_T_PRODUCT_US);
  localparam int LAT_QUOTIENT = `ARI_CYC(`ARI_T_QUOTIENT_US);

  initial
  begin
    if (CNT_W < 1 || (2 ** CNT_W) <= LAT_QUOTIENT)
      $error("CNT_W too narrow for the longest evaluation");
  end

  // =========================================================================
  // state
  // =========================================================================
  ari_mode_t          mode;
  ari_mode_t          mode_q;
  ari_operands_t      opnd;
  ari_state_t         state;
  ari_state_t         next_state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   lat_end;

  // =========================================================================
  // arithmetic, sum, difference and product widened so the true value is visible
  // =========================================================================
  wire logic signed [32:0] sum_w   = 33'(opnd.operand_a) + 33'(opnd.operand_b);
  wire logic signed [32:0] diff_w  = 33'(opnd.operand_a) - 33'(opnd.operand_b);
  wire logic signed [63:0] prod_w  = 64'(opnd.operand_a) * 64'(opnd.operand_b);
  wire logic               div_zero = (opnd.operand_b == 32'sh0);
  // min / -1 is the one quotient that leaves the range
  wire logic               div_wrap = (opnd.operand_a == `ARI_INT_MIN) && (opnd.operand_b == -32'sh1);
  // guarded divisor keeps the divider out of the undefined case
  wire logic signed [31:0] div_den = div_zero ? 32'sh1 : opnd.operand_b;
  // operator truncates toward zero and signs the quotient
  wire logic signed [31:0] quot_w  = opnd.operand_a / div_den;

  wire logic sum_ovf  = sum_w[32] != sum_w[31];
  wire logic diff_ovf = diff_w[32] != diff_w[31];
  // upper 33 bits must all match the sign for the product to fit
  wire logic prod_ovf = !((&prod_w[63:31]) || !(|prod_w[63:31]));
  wire logic quot_ovf = div_zero || div_wrap;

  logic               calc_ovf;
  logic signed [31:0] calc_val;

  always_comb
  begin
    case (mode_q)
      ARI_OP_SUM:      begin calc_val = sum_w[31:0];   calc_ovf = sum_ovf;  end
      ARI_OP_DIFF:     begin calc_val = diff_w[31:0];  calc_ovf = diff_ovf; end
      ARI_OP_PRODUCT:  begin calc_val = prod_w[31:0];  calc_ovf = prod_ovf; end
      ARI_OP_QUOTIENT: begin calc_val = quot_w;        calc_ovf = quot_ovf; end
      default:         begin calc_val = sum_w[31:0];   calc_ovf = sum_ovf;  end
    endcase
  end

  wire logic signed [31:0] next_result = calc_ovf ? result_out : calc_val;

  // =========================================================================
  // evaluation timing
  // =========================================================================
  assign lat_end = (mode_q == ARI_OP_SUM)  ? CNT_W'(LAT_SUM - 2) :
                   (mode_q == ARI_OP_DIFF) ? CNT_W'(LAT_DIFF - 2) :
                   (mode_q == ARI_OP_PRODUCT) ? CNT_W'(LAT_PRODUCT - 2) :
                   CNT_W'(LAT_QUOTIENT - 2);

  // free running: one evaluation follows the next with no start input
  always_comb
  begin
    case (state)
      ARI_ST_LOAD:   next_state = ARI_ST_WAIT;
      ARI_ST_WAIT:   next_state = (cnt == lat_end) ? ARI_ST_COMMIT : ARI_ST_WAIT;
      ARI_ST_COMMIT: next_state = ARI_ST_LOAD;
      default:       next_state = ARI_ST_LOAD;
    endcase
  end

  // =========================================================================
  // registers
  // =========================================================================
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      mode <= INIT_MODE;
    else if (cfg_mode_load)
      mode <= cfg_mode;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state  <= ARI_ST_LOAD;
      cnt    <= '0;
      mode_q <= INIT_MODE;
      opnd   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= (state == ARI_ST_WAIT) ? cnt + 1'b1 : '0;
      if (state == ARI_ST_LOAD)
      begin
        mode_q <= mode;
        opnd   <= operands;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      result_out <= `ARI_RESULT_RST;
      flags      <= '0;
      eval_done  <= 1'b0;
    end
    else
    begin
      eval_done <= (state == ARI_ST_COMMIT);
      if (state == ARI_ST_COMMIT)
      begin
        result_out          <= next_result;
        flags.overflow_flag <= calc_ovf;
        flags.zero_flag     <= (next_result == 32'sh0);
      end
    end
  end

  // =========================================================================
  // checks
  // =========================================================================
  logic [CNT_W:0] since_load;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      since_load <= '0;
    else
      since_load <= (state == ARI_ST_LOAD) ? '0 : since_load + 1'b1;
  end

  // expected latency comes from the full cycle counts, not from the counter end point
  wire logic [CNT_W:0] lat_now = (mode_q == ARI_OP_SUM)     ? (CNT_W+1)'(LAT_SUM) :
                                 (mode_q == ARI_OP_DIFF)    ? (CNT_W+1)'(LAT_DIFF) :
                                 (mode_q == ARI_OP_PRODUCT) ? (CNT_W+1)'(LAT_PRODUCT) :
                                 (CNT_W+1)'(LAT_QUOTIENT);

  a_eval_latency_time:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done |-> since_load == lat_now)
    else $error("evaluation time does not match the operation");

  a_reset_clears_out:
    assert property (@(posedge core_clk)
      !rst_b |=> result_out == 32'sh0 && flags == '0 && !eval_done)
    else $error("result or flags not cleared by reset");

  a_overflow_holds_result:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && flags.overflow_flag |-> result_out == $past(result_out))
    else $error("result changed on overflow");

  a_valid_sum_update:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && !flags.overflow_flag && mode_q == ARI_OP_SUM
        |-> result_out == opnd.operand_a + opnd.operand_b)
    else $error("valid sum not delivered");

  a_zero_flag_tracks:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done |-> flags.zero_flag == (result_out == 32'sh0))
    else $error("zero flag disagrees with result");

  a_divide_zero_ovf:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && mode_q == ARI_OP_QUOTIENT && opnd.operand_b == 32'sh0 |-> flags.overflow_flag)
    else $error("divide by zero not flagged");

  a_max_plus_one:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && mode_q == ARI_OP_SUM && opnd.operand_a == `ARI_INT_MAX && opnd.operand_b == 32'sh1
        |-> flags.overflow_flag)
    else $error("max plus one not flagged");

  a_min_minus_pos:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && mode_q == ARI_OP_DIFF && opnd.operand_a == `ARI_INT_MIN && opnd.operand_b > 32'sh0
        |-> flags.overflow_flag)
    else $error("min minus positive not flagged");

  a_quotient_sign_ok:
    assert property (@(posedge core_clk) disable iff (!rst_b)
      eval_done && !flags.overflow_flag && mode_q == ARI_OP_QUOTIENT && result_out != 32'sh0
        |-> result_out[31] == (opnd.operand_a[31] ^ opnd.operand_b[31]))
    else $error("quotient sign wrong");

endmodule : ari_arith_unit

/* rtl/ari_cfg.svh */
`ifndef ARI_CFG_SVH
`define ARI_CFG_SVH
// ===========================================================================
// evaluation times per operation
// ===========================================================================
`define ARI_CLK_PERIOD_NS 100
`define ARI_T_SUM_US      32
`define ARI_T_DIFF_US     33
`define ARI_T_PRODUCT_US  38
`define ARI_T_QUOTIENT_US 41
// whole cycles: a fixed evaluation time rounds up
`define ARI_CYC(us) (((us) * 1000 + `ARI_CLK_PERIOD_NS - 1) / `ARI_CLK_PERIOD_NS)
// ===========================================================================
// reset value and integer limits
// ===========================================================================
`define ARI_RESULT_RST 32'h0000_0000
`define ARI_INT_MAX    32'h7fff_ffff
`define ARI_INT_MIN    32'h8000_0000
`endif

/* rtl/ari_pkg.sv */
package ari_pkg;
  // operation select
  typedef enum logic [1:0] {
    ARI_OP_SUM      = 2'h0,
    ARI_OP_DIFF     = 2'h1,
    ARI_OP_PRODUCT  = 2'h2,
    ARI_OP_QUOTIENT = 2'h3
  } ari_mode_t;

  typedef enum logic [2:0] {
    ARI_ST_LOAD   = 3'h1,
    ARI_ST_WAIT   = 3'h2,
    ARI_ST_COMMIT = 3'h4
  } ari_state_t;

  typedef struct packed {
    logic signed [31:0] operand_a;
    logic signed [31:0] operand_b;
  } ari_operands_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
  } ari_flags_t;
endpackage : ari_pkg

/* verification/ari_ctl_model.sv */
`timescale 1ns/10ps
module ari_ctl_model
  import ari_pkg::*;
(
  input  wire logic              core_clk,
  output ari_pkg::ari_operands_t operands
);
  initial operands = '{32'sh7fff_ffff, 32'sh0000_0001};
  // ==========================================================
  // operand source
  // the pair is wobbled for one cycle after the sample edge so that a late sample shows up
  task automatic present(input logic signed [31:0] a, input logic signed [31:0] b);
    operands = '{a, b};
    @(posedge core_clk);
    #1 operands = ~operands;
    @(posedge core_clk);
    #1 operands = '{a, b};
  endtask : present
endmodule : ari_ctl_model

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
  import ari_pkg::*;
  logic               core_clk      = 1'b0;
  logic               rst_b         = 1'b0;
  logic               cfg_mode_load = 1'b0;
  ari_mode_t          cfg_mode      = ARI_OP_SUM;
  ari_operands_t      operands;
  logic signed [31:0] result_out;
  ari_flags_t         flags;
  logic               eval_done;
  int                 n_mismatch      = 0;
  int                 samples_checked = 0;
  localparam logic signed [31:0] MAX = 32'sh7fff_ffff;
  localparam logic signed [31:0] MIN = 32'sh8000_0000;

  always #50 core_clk = ~core_clk;

  ari_ctl_model i_ctl (.core_clk(core_clk), .operands(operands));
  ari_arith_unit i_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg_mode_load(cfg_mode_load),
    .cfg_mode(cfg_mode), .operands(operands), .result_out(result_out), .flags(flags),
    .eval_done(eval_done));

  // ==========================================================
  // checking
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // 10 cycles per microsecond at 100 ns
  function automatic int lat(input ari_mode_t m);
    case (m)
      ARI_OP_SUM:  return 320;
      ARI_OP_DIFF: return 330;
      ARI_OP_PRODUCT: return 380;
      default:     return 410;
    endcase
  endfunction : lat

  // bounded wait; n counts edges after the sample edge
  task automatic wait_done(output int n);
    n = 1;
    while (eval_done !== 1'b1 && n < 500)
    begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : wait_done

  // mode is loaded mid-evaluation so it only applies from the next sample edge
  task automatic run(input ari_mode_t m, input logic signed [31:0] a, input logic signed [31:0] b,
                     input logic signed [31:0] exp, input logic ov);
    int n;
    @(posedge core_clk);
    #1 cfg_mode = m;
    cfg_mode_load = 1'b1;
    @(posedge core_clk);
    #1 cfg_mode_load = 1'b0;
    wait_done(n);
    i_ctl.present(a, b);
    wait_done(n);
    chk(n, lat(m));
    chk(result_out, exp);
    chk(flags, {ov, exp == 0});
  endtask : run

  // ==========================================================
  // scenarios
  task automatic t_first();
    int n;
    repeat (3) @(posedge core_clk);
    #1 rst_b = 1'b1;
    chk(result_out, 0);
    chk(flags, 0);
    repeat (2) @(posedge core_clk);
    #1 wait_done(n);
    chk(n, 320);
    chk(result_out, 0);
    chk(flags, 2'b11);
  endtask : t_first

  task automatic t_sum();
    run(ARI_OP_SUM, 42, 1000, 1042, 1'b0);
    run(ARI_OP_SUM, -2048, 1000, -1048, 1'b0);
    run(ARI_OP_SUM, MAX, MIN, -1, 1'b0);
    run(ARI_OP_SUM, MAX, 1, -1, 1'b1);
  endtask : t_sum

  task automatic t_diff();
    run(ARI_OP_DIFF, 1134, 42, 1092, 1'b0);
    run(ARI_OP_DIFF, MIN, 3, 1092, 1'b1);
    run(ARI_OP_DIFF, -4096, 1000, -5096, 1'b0);
    run(ARI_OP_DIFF, -4096, -1000, -3096, 1'b0);
  endtask : t_diff

  task automatic t_prod();
    run(ARI_OP_PRODUCT, 12, 12, 144, 1'b0);
    run(ARI_OP_PRODUCT, 1000042, 2401, 144, 1'b1);
    run(ARI_OP_PRODUCT, -1000, 10, -10000, 1'b0);
  endtask : t_prod

  task automatic t_quot();
    run(ARI_OP_QUOTIENT, 1024, 35, 29, 1'b0);
    run(ARI_OP_QUOTIENT, 1024, 0, 29, 1'b1);
    run(ARI_OP_QUOTIENT, 1000, -10, -100, 1'b0);
    run(ARI_OP_QUOTIENT, -1000, -10, 100, 1'b0);
    run(ARI_OP_QUOTIENT, MIN, -1, 100, 1'b1);
    run(ARI_OP_QUOTIENT, 10, 100, 0, 1'b0);
  endtask : t_quot

  task automatic t_rst_mid();
    int n;
    repeat (100) @(posedge core_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(result_out, 0);
    chk({flags, eval_done}, 0);
    rst_b = 1'b1;
    // mode falls back to sum; the first edge after release samples the pair 10, 100
    repeat (2) @(posedge core_clk);
    #1 wait_done(n);
    chk(n, 320);
    chk(result_out, 110);
    chk(flags, 0);
  endtask : t_rst_mid

  initial
  begin
    t_first();
    t_sum();
    t_diff();
    t_prod();
    t_quot();
    t_rst_mid();
    test_done();
  end

  initial
  begin
    #3_000_000;
    n_mismatch++;
    test_done();
  end
endmodule : tb
